/* hdl/pmep_pkg.sv */
// Purpose : shared constants for the power-management event pin block
// Assumes : single 200 MHz clock, asynchronous active-high reset
// Notes   : no register bus; all control bits are plain ports
package pmep_pkg;
  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned CLK_MHZ          = 200;   // clock rate
  localparam int unsigned EXT_REQ_MIN_US   = 32;    // least request width
  // cycles the request must stay low before it counts
  localparam int unsigned EXT_REQ_CYC      = EXT_REQ_MIN_US * CLK_MHZ;
  localparam int unsigned SYNC_STAGES      = 3;     // pin synchroniser depth
  // ****************************************
  // widths and reset values
  // ****************************************
  localparam int unsigned PWR_CTL_W        = 6;     // power-control outputs
  localparam int unsigned DECODE_W         = 32;    // pci address width
  localparam int unsigned NUM_RANGES       = 4;     // access detect ranges
  localparam int unsigned NUM_ASYNC        = 6;     // synchronised inputs
  localparam logic [5:0]  PWR_CTL_RST      = 6'h3F; // all high in reset
  // pin rest levels: pull-ups idle high, the event pin's pull-down idles low
  localparam logic [NUM_ASYNC-1:0] PIN_IDLE = 6'h1F;
  // positions of the synchronised inputs
  localparam int unsigned IN_ACT  = 0;
  localparam int unsigned IN_BTN  = 1;
  localparam int unsigned IN_BAT  = 2;
  localparam int unsigned IN_RING = 3;
  localparam int unsigned IN_EXT  = 4;
  localparam int unsigned IN_EVT  = 5;
  // management interrupt source bits
  localparam int unsigned SRC_W   = 5;
  localparam int unsigned SRC_SW  = 0;
  localparam int unsigned SRC_BTN = 1;
  localparam int unsigned SRC_BAT = 2;
  localparam int unsigned SRC_EXT = 3;
  localparam int unsigned SRC_RNG = 4;
  // resume well states, gray from awake through suspend to wake; wake back to awake flips both bits
  typedef enum logic [1:0] {
    PMEP_AWAKE   = 2'b00,
    PMEP_SUSPEND = 2'b01,
    PMEP_WAKE    = 2'b11
  } pmep_rsm_e;
endpackage : pmep_pkg

/* hdl/pmep_top.sv */
// Purpose : management interrupt, stop-clock, suspend switch, power-control
//           outputs, wake inputs and peripheral access decode flag
// Assumes : pins are asynchronous; cpu reset/init come from on-chip logic
// Notes   : outputs are all registered; resume well has its own reset
`timescale 1ns/10ps
`default_nettype none

// How it works
// - enabled events pull management interrupt low
// - cpu reset or init forces interrupt negated
// - stop-clock asserts on software or hardware stop, synchronous
// - suspend output switches off non-critical power
// - enabled activity input blocks idle entry
// - enabled button raises management interrupt
// - enabled battery-low raises management interrupt
// - optional: no resume while battery low
// - resume reset clears resume well alone
// - ring indicate wakes suspended system
// - external request low asserts interrupt
// - outside event drives boost and throttle-break
// - pin mode bit, default dma request
// - enabled range match asserts access decode
// - decode flagged even when not target
// - output pin mode bit, default dma ack
module pmep_top
(
  // clock and resets
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   resume_well_reset_n_i,
  // cpu reset state
  input  wire logic                   cpu_reset_out_i,
  input  wire logic                   cpu_init_i,
  // software controls
  input  wire logic                   sw_mgmt_event_i,
  input  wire logic                   sw_clock_stop_i,
  input  wire logic                   sw_suspend_i,
  input  wire logic                   hw_stop_event_i,
  input  wire logic [pmep_pkg::SRC_W-1:0] src_enable_i,
  input  wire logic                   mgmt_clear_i,
  input  wire logic                   activity_enable_i,
  input  wire logic                   battery_low_n_block_resume_i,
  input  wire logic                   ring_wake_enable_i,
  input  wire logic [pmep_pkg::PWR_CTL_W-1:0] power_ctl_set_i,
  input  wire logic                   disk_oe_mode_i,
  input  wire logic                   disk_out_enable_n_i,
  input  wire logic                   rtc_ale_mode_i,
  input  wire logic                   rtc_addr_latch_en_i,
  input  wire logic                   event_pin_mode_i,
  input  wire logic                   decode_pin_mode_i,
  input  wire logic                   board_dma_ack2_n_i,
  // peripheral access decode
  input  wire logic                   pci_addr_valid_i,
  input  wire logic                   pci_is_io_i,
  input  wire logic [pmep_pkg::DECODE_W-1:0] pci_addr_i,
  input  wire logic [pmep_pkg::DECODE_W-1:0] range_base_i [pmep_pkg::NUM_RANGES],
  input  wire logic [pmep_pkg::DECODE_W-1:0] range_mask_i [pmep_pkg::NUM_RANGES],
  input  wire logic [pmep_pkg::NUM_RANGES-1:0] range_is_io_i,
  input  wire logic [pmep_pkg::NUM_RANGES-1:0] range_enable_i,
  // asynchronous pins
  input  wire logic                   activity_in_n_i,
  input  wire logic                   suspend_button_n_i,
  input  wire logic                   battery_low_n_i,
  input  wire logic                   ring_indicate_n_i,
  input  wire logic                   ext_mgmt_request_n_i,
  input  wire logic                   outside_event_n_i,
  // outputs
  output logic                        mgmt_interrupt_n_o,
  output logic                        cpu_clock_stop_n_o,
  output logic                        suspend_power_off_n_o,
  output logic [pmep_pkg::PWR_CTL_W-1:0] power_ctl_out_o,
  output logic                        access_decode_n_o,
  output logic                        board_dma_req2_o,
  output logic                        clock_boost_event_o,
  output logic                        throttle_break_event_o,
  output logic                        idle_block_o,
  output logic                        wake_request_o,
  output logic [pmep_pkg::SRC_W-1:0]  mgmt_status_o
);
  import pmep_pkg::*;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // ****************************************
  // helpers
  // ****************************************
  // masked address compare, used for every table entry
  function automatic logic range_hit(input logic [DECODE_W-1:0] a,
                                     input logic [DECODE_W-1:0] b,
                                     input logic [DECODE_W-1:0] m);
    range_hit = ((a ^ b) & m) == '0;
  endfunction : range_hit

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [NUM_ASYNC-1:0] pins_n;                  // raw pins, active low
  logic [NUM_ASYNC-1:0] s1_q, s2_q, s3_q;        // three-stage chain
  logic [NUM_ASYNC-1:0] stab_q;                  // agreed level, active low
  assign pins_n = {outside_event_n_i, ext_mgmt_request_n_i, ring_indicate_n_i,
                   battery_low_n_i, suspend_button_n_i, activity_in_n_i};
  // chain resets to each pin's rest level so no false edge at release
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q   <= PIN_IDLE;
      s2_q   <= PIN_IDLE;
      s3_q   <= PIN_IDLE;
      stab_q <= PIN_IDLE;
    end else begin
      s1_q <= pins_n;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // a change counts only when stage two and three agree
      for (int i = 0; i < NUM_ASYNC; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          stab_q[i] <= s3_q[i];
        end
      end
    end
  end

  logic act_l, btn_l, bat_l, ring_l, ext_l, evt_l; // active-high levels
  assign act_l  = ~stab_q[IN_ACT];
  assign btn_l  = ~stab_q[IN_BTN];
  assign bat_l  = ~stab_q[IN_BAT];
  assign ring_l = ~stab_q[IN_RING];
  assign ext_l  = ~stab_q[IN_EXT];
  assign evt_l  = ~stab_q[IN_EVT];

  // ****************************************
  // external request width filter
  // ****************************************
  // the request is armed by a high level but must stay low its full width;
  // shorter glitches are dropped rather than half-taken
  logic [$clog2(EXT_REQ_CYC+1)-1:0] ext_cnt_q;   // low-time counter
  logic ext_armed_q;                             // high level seen, not yet fired
  logic ext_fire;                                // one-cycle event
  assign ext_fire = ext_armed_q && ext_l &&
                    (ext_cnt_q == ($bits(ext_cnt_q))'(EXT_REQ_CYC - 1));

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_cnt_q   <= '0;
      ext_armed_q <= 1'b0;
    end else if (!ext_l) begin
      ext_cnt_q   <= '0;
      ext_armed_q <= 1'b1;                       // high level re-arms
    end else if (ext_armed_q) begin
      if (ext_fire) begin
        ext_armed_q <= 1'b0;
      end else begin
        ext_cnt_q <= ext_cnt_q + 1'b1;
      end
    end
  end
  // ****************************************
  // edge detectors on synchronised levels
  // ****************************************
  logic btn_d_q, bat_d_q;                        // previous levels
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      btn_d_q <= 1'b0;
      bat_d_q <= 1'b0;
    end else begin
      btn_d_q <= btn_l;
      bat_d_q <= bat_l;
    end
  end
  // ****************************************
  // resume well: suspend state and wake
  // ****************************************
  pmep_rsm_e rsm_q;                              // resume-well state
  logic      wake_ok;                            // wake not blocked
  logic      wake_src;                           // any wake cause
  assign wake_ok  = !(battery_low_n_block_resume_i && bat_l);
  assign wake_src = (ring_l && ring_wake_enable_i)
                  || (btn_l && !btn_d_q && src_enable_i[SRC_BTN]);

  // own reset only; pci reset keeps the suspend state but forces suspend_power_off_n_o high while held
  always_ff @(posedge ref_clk_i or negedge resume_well_reset_n_i) begin
    if (!resume_well_reset_n_i) begin
      rsm_q <= PMEP_AWAKE;
    end else begin
      case (rsm_q)
        PMEP_AWAKE:   if (sw_suspend_i) rsm_q <= PMEP_SUSPEND;
        PMEP_SUSPEND: if (wake_src && wake_ok) rsm_q <= PMEP_WAKE;
        PMEP_WAKE:    rsm_q <= PMEP_AWAKE;       // one-cycle wake pulse
        default:      rsm_q <= PMEP_AWAKE;
      endcase
    end
  end

  // ****************************************
  // management interrupt sources
  // ****************************************
  logic [SRC_W-1:0] src_set;                     // this cycle's events
  logic [SRC_W-1:0] stat_q;                      // sticky causes
  logic             cpu_in_reset;
  logic             dec_hit;                     // any enabled match
  assign cpu_in_reset = cpu_reset_out_i || cpu_init_i;
  always_comb begin
    src_set          = '0;
    src_set[SRC_SW]  = sw_mgmt_event_i;
    src_set[SRC_BTN] = btn_l && !btn_d_q;
    src_set[SRC_BAT] = bat_l && !bat_d_q;
    src_set[SRC_EXT] = ext_fire;
    src_set[SRC_RNG] = ring_l && (rsm_q == PMEP_SUSPEND);
    src_set          = src_set & src_enable_i;
  end

  // set beats clear so an event in the clear cycle survives
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stat_q <= '0;
    end else begin
      stat_q <= (mgmt_clear_i ? '0 : stat_q) | src_set;
    end
  end
  // ****************************************
  // registered outputs
  // ****************************************
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mgmt_interrupt_n_o    <= 1'b1;
      cpu_clock_stop_n_o    <= 1'b1;
      suspend_power_off_n_o <= 1'b1;
      power_ctl_out_o       <= PWR_CTL_RST;
      access_decode_n_o     <= 1'b1;
    end else begin
      // cpu reset masks the interrupt, causes stay latched
      mgmt_interrupt_n_o <= cpu_in_reset ? 1'b1 : ~|stat_q;
      cpu_clock_stop_n_o <= ~(sw_clock_stop_i || hw_stop_event_i);
      suspend_power_off_n_o <= ~(rsm_q == PMEP_SUSPEND);
      power_ctl_out_o <= power_ctl_set_i;
      if (disk_oe_mode_i) begin
        power_ctl_out_o[5] <= disk_out_enable_n_i;
      end
      if (rtc_ale_mode_i) begin
        power_ctl_out_o[4] <= rtc_addr_latch_en_i;
      end
      // shared pin: decode flag or dma ack, ack after reset
      access_decode_n_o <= decode_pin_mode_i ? ~dec_hit
                                             : board_dma_ack2_n_i;
    end
  end

  // ****************************************
  // peripheral access decode
  // ****************************************
  // target claim is not an input: any matching cycle is flagged
  always_comb begin
    dec_hit = 1'b0;
    for (int r = 0; r < NUM_RANGES; r++) begin
      if (pci_addr_valid_i && range_enable_i[r] &&
          (range_is_io_i[r] == pci_is_io_i) &&
          range_hit(pci_addr_i, range_base_i[r], range_mask_i[r])) begin
        dec_hit = 1'b1;
      end
    end
  end

  // ****************************************
  // event pin, activity and status
  // ****************************************
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      board_dma_req2_o       <= 1'b0;
      clock_boost_event_o    <= 1'b0;
      throttle_break_event_o <= 1'b0;
      idle_block_o           <= 1'b0;
      wake_request_o         <= 1'b0;
      mgmt_status_o          <= '0;
    end else begin
      // mode low (default) routes the pin to the dma request
      board_dma_req2_o       <= !event_pin_mode_i && !evt_l;
      clock_boost_event_o    <= event_pin_mode_i && evt_l;
      throttle_break_event_o <= event_pin_mode_i && evt_l;
      idle_block_o           <= activity_enable_i && act_l;
      wake_request_o         <= (rsm_q == PMEP_WAKE);
      mgmt_status_o          <= stat_q;
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  property p_cpu_mask;
    cpu_in_reset |=> mgmt_interrupt_n_o;
  endproperty
  a_cpu_mask: assert property (p_cpu_mask)
    else $error("irq during cpu reset");
  property p_irq_on_src;
    (|src_set && !cpu_in_reset) ##1 !cpu_in_reset |=> !mgmt_interrupt_n_o;
  endproperty
  a_irq_on_src: assert property (p_irq_on_src)
    else $error("enabled event gave no interrupt");
  property p_stop;
    (sw_clock_stop_i || hw_stop_event_i) |=> !cpu_clock_stop_n_o;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop clock not asserted");
  property p_idle;
    !activity_enable_i |=> !idle_block_o;
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle blocked while disabled");
  // resume well keeps its own reset, so it overrides the default
  property p_batblock;
    disable iff (!resume_well_reset_n_i)
      (rsm_q == PMEP_SUSPEND && battery_low_n_block_resume_i && bat_l)
        |=> rsm_q != PMEP_WAKE;
  endproperty
  a_batblock: assert property (p_batblock)
    else $error("resumed under battery low");
  property p_pwr;
    !rst_i && !disk_oe_mode_i && !rtc_ale_mode_i
      |=> power_ctl_out_o == $past(power_ctl_set_i);
  endproperty
  a_pwr: assert property (p_pwr)
    else $error("power control mismatch");
  property p_dec;
    decode_pin_mode_i && dec_hit |=> !access_decode_n_o;
  endproperty
  a_dec: assert property (p_dec)
    else $error("decode not flagged");
  property p_ext;
    ext_fire |-> $past(ext_l, 3) && ext_armed_q;
  endproperty
  a_ext: assert property (p_ext)
    else $error("short request fired");
  c_irq:   cover property (@(posedge ref_clk_i) !mgmt_interrupt_n_o);
  c_wake:  cover property (@(posedge ref_clk_i) wake_request_o);
  c_dec:   cover property (@(posedge ref_clk_i) !access_decode_n_o);
endmodule : pmep_top
`default_nettype wire

/* verif/pmep_pins_model.sv */
// Purpose : far side of the pins: wake sources, battery, event requests
// Assumes : pins rest at their pull levels between uses
// Notes   : driven only through its tasks, one level change per edge
`timescale 1ns/10ps
`default_nettype none
module pmep_pins_model (
  // clock and device output
  input  wire logic                           ref_clk_i,
  input  wire logic                           mgmt_interrupt_n_i,
  // pins, indexed as the package input positions
  output logic [pmep_pkg::NUM_ASYNC-1:0]      pins_o
);
  import pmep_pkg::*;
  // pull-ups hold inputs high, the event pin's pull-down holds it low
  initial pins_o = 6'h1F;

  // drive one pin to a level for n cycles, then let it fall back to rest
  task automatic hold(input int idx, input logic lvl, input int n);
    @(posedge ref_clk_i) pins_o[idx] <= lvl;
    repeat (n) @(posedge ref_clk_i);
    pins_o[idx] <= (idx == IN_EVT) ? 1'b0 : 1'b1;
  endtask : hold

  // battery stays low until the interrupt shows, bounded by limit
  task automatic battery_low(input int limit);
    int k;
    @(posedge ref_clk_i) pins_o[IN_BAT] <= 1'b0;
    for (k = 0; k < limit && mgmt_interrupt_n_i !== 1'b0; k++) begin
      @(posedge ref_clk_i);
    end
    pins_o[IN_BAT] <= 1'b1;
  endtask : battery_low

  // request held past the least width, margin covers the synchroniser
  task automatic ext_request();
    hold(IN_EXT, 1'b0, EXT_REQ_CYC + 200);
  endtask : ext_request
endmodule : pmep_pins_model
`default_nettype wire

/* verif/pmep_top_tb_top.sv */
// Purpose : self-checking bench for the power management event pins
// Assumes : 200 MHz clock, pins driven by the far-side model
// Notes   : waits are bounded; an overrun ends the run as a failure
`timescale 1ns/10ps
`default_nettype none
module pmep_top_tb_top;
  import pmep_pkg::*;
  // design stimulus and observation, named as the design ports
  logic ref_clk_i, rst_i, resume_well_reset_n_i, cpu_reset_out_i;
  logic cpu_init_i, sw_mgmt_event_i, sw_clock_stop_i, sw_suspend_i;
  logic hw_stop_event_i, mgmt_clear_i, activity_enable_i;
  logic battery_low_n_block_resume_i, ring_wake_enable_i, disk_oe_mode_i;
  logic disk_out_enable_n_i, rtc_ale_mode_i, rtc_addr_latch_en_i;
  logic event_pin_mode_i, decode_pin_mode_i, board_dma_ack2_n_i;
  logic pci_addr_valid_i, pci_is_io_i, mgmt_interrupt_n_o;
  logic cpu_clock_stop_n_o, suspend_power_off_n_o, access_decode_n_o;
  logic board_dma_req2_o, clock_boost_event_o, throttle_break_event_o;
  logic idle_block_o, wake_request_o;
  logic [SRC_W-1:0]      src_enable_i, mgmt_status_o;
  logic [PWR_CTL_W-1:0]  power_ctl_set_i, power_ctl_out_o;
  logic [DECODE_W-1:0]   pci_addr_i;
  logic [DECODE_W-1:0]   range_base_i [NUM_RANGES];
  logic [DECODE_W-1:0]   range_mask_i [NUM_RANGES];
  logic [NUM_RANGES-1:0] range_is_io_i, range_enable_i;
  logic [NUM_ASYNC-1:0]  pins;
  wire logic activity_in_n_i = pins[IN_ACT], ring_indicate_n_i = pins[IN_RING];
  wire logic suspend_button_n_i = pins[IN_BTN], battery_low_n_i = pins[IN_BAT];
  wire logic ext_mgmt_request_n_i = pins[IN_EXT];
  wire logic outside_event_n_i = pins[IN_EVT];
  int n_errors, n_tests, wake_cnt, dec_cnt, w0, i;

  pmep_top DUT (.*);
  pmep_pins_model model (
    .ref_clk_i          (ref_clk_i),
    .mgmt_interrupt_n_i (mgmt_interrupt_n_o),
    .pins_o             (pins)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  // count one-cycle pulses so a short output cannot slip past unseen
  always @(posedge ref_clk_i) begin
    if (wake_request_o === 1'b1) wake_cnt++;
    if (access_decode_n_o === 1'b0) dec_cnt++;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // selects one single-bit output by number
  function automatic logic probe(input int s);
    case (s)
      0: probe = mgmt_interrupt_n_o;
      1: probe = cpu_clock_stop_n_o;
      2: probe = suspend_power_off_n_o;
      3: probe = idle_block_o;
      4: probe = clock_boost_event_o;
      default: probe = board_dma_req2_o;
    endcase
  endfunction : probe
  task automatic wait_for(input string nm, input int s, input logic v,
                          input int lim);
    int k;
    for (k = 0; k < lim && probe(s) !== v; k++) @(negedge ref_clk_i);
    chk(nm, probe(s), v);
    if (probe(s) !== v) final_report();
  endtask : wait_for
  task automatic stays(input string nm, input int s, input logic v,
                       input int n);
    int k;
    for (k = 0; k < n && probe(s) === v; k++) @(negedge ref_clk_i);
    chk(nm, probe(s), v);
  endtask : stays
  // interrupt low with the given cause, then cleared back high
  task automatic got_int(input string nm, input int b, input int lim);
    wait_for(nm, 0, 1'b0, lim);
    chk(nm, mgmt_status_o[b], 1);
    @(posedge ref_clk_i) mgmt_clear_i <= 1'b1;
    @(posedge ref_clk_i) mgmt_clear_i <= 1'b0;
    wait_for(nm, 0, 1'b1, 8);
  endtask : got_int
  // one valid address cycle, then whether the decode flag went low
  task automatic dec(input logic [31:0] a, input logic io,
                     input logic [3:0] en, input int hit);
    int d0;
    d0 = dec_cnt;
    @(posedge ref_clk_i) pci_addr_i <= a;
    pci_is_io_i <= io;
    range_enable_i <= en;
    pci_addr_valid_i <= 1'b1;
    @(posedge ref_clk_i) pci_addr_valid_i <= 1'b0;
    repeat (4) @(negedge ref_clk_i);
    chk("decode", dec_cnt != d0, hit);
  endtask : dec

  initial begin
    {rst_i, board_dma_ack2_n_i, disk_out_enable_n_i} = 3'h7;
    {resume_well_reset_n_i, cpu_reset_out_i, cpu_init_i} = 3'h0;
    {sw_mgmt_event_i, sw_clock_stop_i, sw_suspend_i} = 3'h0;
    {hw_stop_event_i, mgmt_clear_i, activity_enable_i} = 3'h0;
    {battery_low_n_block_resume_i, ring_wake_enable_i, disk_oe_mode_i} = 3'h0;
    {rtc_ale_mode_i, rtc_addr_latch_en_i, event_pin_mode_i} = 3'h0;
    {decode_pin_mode_i, pci_addr_valid_i, pci_is_io_i} = 3'h0;
    src_enable_i = 5'h1D;
    power_ctl_set_i = 6'h00;
    pci_addr_i = 32'h0000_0000;
    for (i = 0; i < NUM_RANGES; i++) begin
      range_base_i[i] = 32'h0000_0000;
      range_mask_i[i] = 32'hFFFF_FFFF;
    end
    range_base_i[0] = 32'h0000_03F0;
    range_mask_i[0] = 32'hFFFF_FFF8;
    range_base_i[1] = 32'h000A_0000;
    range_mask_i[1] = 32'hFFFE_0000;
    range_is_io_i = 4'h1;
    range_enable_i = 4'h0;
    repeat (3) @(negedge ref_clk_i);
    chk("reset_outs", {mgmt_interrupt_n_o, cpu_clock_stop_n_o,
        suspend_power_off_n_o, access_decode_n_o, power_ctl_out_o},
        10'h3FF);
    @(posedge ref_clk_i) rst_i <= 1'b0;
    resume_well_reset_n_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i) power_ctl_set_i <= 6'h2A;
    repeat (2) @(negedge ref_clk_i);
    chk("power_ctl", power_ctl_out_o, 6'h2A);
    @(posedge ref_clk_i) {disk_oe_mode_i, rtc_ale_mode_i} <= 2'h3;
    {disk_out_enable_n_i, rtc_addr_latch_en_i} <= 2'h1;
    repeat (2) @(negedge ref_clk_i);
    chk("alternates", power_ctl_out_o, 6'h1A);
    $display("test power_ctl done");
    @(posedge ref_clk_i) sw_mgmt_event_i <= 1'b1;
    @(posedge ref_clk_i) sw_mgmt_event_i <= 1'b0;
    got_int("sw_event", SRC_SW, 8);
    for (i = 0; i < 2; i++) begin
      @(posedge ref_clk_i) {cpu_reset_out_i, cpu_init_i} <= 2'h1 << i;
      sw_mgmt_event_i <= 1'b1;
      @(posedge ref_clk_i) sw_mgmt_event_i <= 1'b0;
      stays("masked", 0, 1'b1, 10);
      @(posedge ref_clk_i) mgmt_clear_i <= 1'b1;
      @(posedge ref_clk_i) mgmt_clear_i <= 1'b0;
      {cpu_reset_out_i, cpu_init_i} <= 2'h0;
    end
    model.hold(IN_BTN, 1'b0, 10);
    stays("btn_off", 0, 1'b1, 12);
    @(posedge ref_clk_i) src_enable_i <= 5'h1B;
    model.hold(IN_BTN, 1'b0, 10);
    got_int("button", SRC_BTN, 20);
    @(posedge ref_clk_i) src_enable_i <= 5'h1F;
    model.battery_low(60);
    got_int("battery", SRC_BAT, 8);
    model.hold(IN_EXT, 1'b0, 100);
    stays("ext_short", 0, 1'b1, 20);
    fork
      model.ext_request();
    join_none
    got_int("ext_req", SRC_EXT, 7000);
    $display("test mgmt_interrupt done");
    for (i = 0; i < 2; i++) begin
      @(posedge ref_clk_i) {sw_clock_stop_i, hw_stop_event_i} <= 2'h1 << i;
      wait_for("stop_on", 1, 1'b0, 8);
      @(posedge ref_clk_i) {sw_clock_stop_i, hw_stop_event_i} <= 2'h0;
      wait_for("stop_off", 1, 1'b1, 8);
    end
    $display("test stop_clock done");
    @(posedge ref_clk_i) {src_enable_i, ring_wake_enable_i} <= 6'h37;
    battery_low_n_block_resume_i <= 1'b1;
    sw_suspend_i <= 1'b1;
    @(posedge ref_clk_i) sw_suspend_i <= 1'b0;
    wait_for("suspend", 2, 1'b0, 8);
    w0 = wake_cnt;
    fork
      model.hold(IN_BAT, 1'b0, 60);
      begin
        repeat (10) @(posedge ref_clk_i);
        model.hold(IN_RING, 1'b0, 10);
      end
    join
    chk("blocked", wake_cnt, w0);
    model.hold(IN_RING, 1'b0, 10);
    wait_for("resumed", 2, 1'b1, 30);
    chk("wake_pulse", wake_cnt, w0 + 1);
    got_int("ring", SRC_RNG, 8);
    @(posedge ref_clk_i) sw_suspend_i <= 1'b1;
    @(posedge ref_clk_i) sw_suspend_i <= 1'b0;
    wait_for("suspend2", 2, 1'b0, 8);
    @(posedge ref_clk_i) resume_well_reset_n_i <= 1'b0;
    @(posedge ref_clk_i) resume_well_reset_n_i <= 1'b1;
    wait_for("rsm_reset", 2, 1'b1, 8);
    chk("main_kept", power_ctl_out_o, 6'h1A);
    $display("test suspend done");
    @(posedge ref_clk_i) activity_enable_i <= 1'b1;
    fork
      model.hold(IN_ACT, 1'b0, 20);
    join_none
    wait_for("activity", 3, 1'b1, 12);
    wait_for("act_end", 3, 1'b0, 40);
    @(posedge ref_clk_i) activity_enable_i <= 1'b0;
    fork
      model.hold(IN_ACT, 1'b0, 20);
    join_none
    stays("act_off", 3, 1'b0, 20);
    fork
      model.hold(IN_EVT, 1'b1, 20);
    join_none
    wait_for("dma_req", 5, 1'b1, 12);
    chk("boost_dma", clock_boost_event_o, 0);
    repeat (30) @(posedge ref_clk_i);
    @(negedge ref_clk_i) chk("dma_idle", board_dma_req2_o, 0);
    @(posedge ref_clk_i) event_pin_mode_i <= 1'b1;
    wait_for("boost", 4, 1'b1, 12);
    chk("throttle", throttle_break_event_o, 1);
    $display("test event_pin done");
    @(posedge ref_clk_i) board_dma_ack2_n_i <= 1'b0;
    repeat (3) @(negedge ref_clk_i);
    chk("dma_ack", access_decode_n_o, 0);
    @(posedge ref_clk_i) board_dma_ack2_n_i <= 1'b1;
    decode_pin_mode_i <= 1'b1;
    repeat (3) @(negedge ref_clk_i);
    chk("dec_idle", access_decode_n_o, 1);
    dec(32'h0000_03F4, 1'b1, 4'h3, 1);
    dec(32'h0000_0400, 1'b1, 4'h3, 0);
    dec(32'h000A_1234, 1'b0, 4'h3, 1);
    dec(32'h000A_1234, 1'b1, 4'h3, 0);
    dec(32'h0000_03F4, 1'b1, 4'h2, 0);
    $display("test decode done");
    final_report();
  end
endmodule : pmep_top_tb_top
`default_nettype wire
